/* hw/rssd_alu.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rssd_defs.svh"
module rssd_alu
(
  // operands and result
  rssd_alu_if.alu bus
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] inv_mem;
  logic [7:0] dec_val;
  logic [7:0] inc_val;
  logic [7:0] bit_mask;

  // shared arithmetic
  always_comb
  begin
    inv_mem = ~bus.mem;
    sum = {1'b0, bus.acc} + {1'b0, inv_mem} + {8'h00, bus.flags.carry_flag};
    low_sum = {1'b0, bus.acc[`RSSD_NIB_MSB:0]} + {1'b0, inv_mem[`RSSD_NIB_MSB:0]}
      + {4'h0, bus.flags.carry_flag};
    dec_val = bus.mem - `RSSD_ONE;
    inc_val = bus.mem + `RSSD_ONE;
    bit_mask = `RSSD_ONE << bus.bit_sel;
  end

  // per instruction result
  always_comb
  begin
    bus.res = '0;
    bus.res.flags = bus.flags;
    bus.res.acc = bus.acc;
    bus.res.mem = bus.mem;
    case (bus.op)
      rssd_pkg::rotate_left_mem:
      begin
        bus.res.mem = {bus.mem[6:0], bus.mem[`RSSD_MSB]};
        bus.res.mem_we = 1'b1;
      end
      rssd_pkg::rotate_left_to_acc:
      begin
        bus.res.acc = {bus.mem[6:0], bus.mem[`RSSD_MSB]};
        bus.res.acc_we = 1'b1;
      end
      rssd_pkg::rotate_left_carry_mem:
      begin
        bus.res.mem = {bus.mem[6:0], bus.flags.carry_flag};
        bus.res.flags.carry_flag = bus.mem[`RSSD_MSB];
        bus.res.mem_we = 1'b1;
      end
      rssd_pkg::rotate_left_carry_to_acc:
      begin
        bus.res.acc = {bus.mem[6:0], bus.flags.carry_flag};
        bus.res.flags.carry_flag = bus.mem[`RSSD_MSB];
        bus.res.acc_we = 1'b1;
      end
      rssd_pkg::rotate_right_mem:
      begin
        bus.res.mem = {bus.mem[`RSSD_LSB], bus.mem[7:1]};
        bus.res.mem_we = 1'b1;
      end
      rssd_pkg::rotate_right_to_acc:
      begin
        bus.res.acc = {bus.mem[`RSSD_LSB], bus.mem[7:1]};
        bus.res.acc_we = 1'b1;
      end
      rssd_pkg::rotate_right_carry_mem:
      begin
        bus.res.mem = {bus.flags.carry_flag, bus.mem[7:1]};
        bus.res.flags.carry_flag = bus.mem[`RSSD_LSB];
        bus.res.mem_we = 1'b1;
      end
      rssd_pkg::rotate_right_carry_to_acc:
      begin
        bus.res.acc = {bus.flags.carry_flag, bus.mem[7:1]};
        bus.res.flags.carry_flag = bus.mem[`RSSD_LSB];
        bus.res.acc_we = 1'b1;
      end
      rssd_pkg::subtract_borrow_to_acc, rssd_pkg::subtract_borrow_to_mem:
      begin
        // acc + ~mem + carry, signed overflow from operand signs
        bus.res.flags.carry_flag = sum[8];
        bus.res.flags.aux_carry_flag = low_sum[4];
        bus.res.flags.zero_flag = (sum[7:0] == `RSSD_ZERO);
        bus.res.flags.overflow_flag = (bus.acc[7] == inv_mem[7]) && (sum[7] != bus.acc[7]);
        if (bus.op == rssd_pkg::subtract_borrow_to_acc)
        begin
          bus.res.acc = sum[7:0];
          bus.res.acc_we = 1'b1;
        end
        else
        begin
          bus.res.mem = sum[7:0];
          bus.res.mem_we = 1'b1;
        end
      end
      rssd_pkg::decrement_skip_zero:
      begin
        bus.res.mem = dec_val;
        bus.res.mem_we = 1'b1;
        bus.res.skip = (dec_val == `RSSD_ZERO);
      end
      rssd_pkg::decrement_to_acc_skip_zero:
      begin
        bus.res.acc = dec_val;
        bus.res.acc_we = 1'b1;
        bus.res.skip = (dec_val == `RSSD_ZERO);
      end
      rssd_pkg::increment_skip_zero:
      begin
        bus.res.mem = inc_val;
        bus.res.mem_we = 1'b1;
        bus.res.skip = (inc_val == `RSSD_ZERO);
      end
      rssd_pkg::increment_to_acc_skip_zero:
      begin
        bus.res.acc = inc_val;
        bus.res.acc_we = 1'b1;
        bus.res.skip = (inc_val == `RSSD_ZERO);
      end
      rssd_pkg::set_byte:
      begin
        bus.res.mem = `RSSD_ALL_ONES;
        bus.res.mem_we = 1'b1;
      end
      rssd_pkg::set_bit:
      begin
        bus.res.mem = bus.mem | bit_mask;
        bus.res.mem_we = 1'b1;
      end
      rssd_pkg::skip_bit_nonzero:
      begin
        bus.res.skip = |(bus.mem & bit_mask);
      end
      default:
      begin
        bus.res.skip = 1'b0;
      end
    endcase
  end
endmodule // rssd_alu
`default_nettype wire

/* hw/rssd_defs.svh */
`ifndef RSSD_DEFS_SVH
`define RSSD_DEFS_SVH
// widths
`define RSSD_DATA_W 8
`define RSSD_BIT_SEL_W 3
// bit positions within a data byte
`define RSSD_MSB 7
`define RSSD_LSB 0
`define RSSD_NIB_MSB 3
// reset values
`define RSSD_ACC_RESET 8'h00
`define RSSD_CARRY_RESET 1'b0
`define RSSD_FLAG_RESET 1'b0
// constants of the operations
`define RSSD_ALL_ONES 8'hff
`define RSSD_ONE 8'h01
`define RSSD_ZERO 8'h00
// cycles spent by an instruction
`define RSSD_CYCLES_SKIP 2
`define RSSD_CYCLES_PLAIN 1
`endif

/* hw/rssd_pkg.sv */
package rssd_pkg;
  // instruction selector presented by the decoder
  typedef enum logic [4:0] {
    op_none = 5'h00,
    rotate_left_mem = 5'h01,
    rotate_left_to_acc = 5'h02,
    rotate_left_carry_mem = 5'h03,
    rotate_left_carry_to_acc = 5'h04,
    rotate_right_mem = 5'h05,
    rotate_right_to_acc = 5'h06,
    rotate_right_carry_mem = 5'h07,
    rotate_right_carry_to_acc = 5'h08,
    subtract_borrow_to_acc = 5'h09,
    subtract_borrow_to_mem = 5'h0a,
    decrement_skip_zero = 5'h0b,
    decrement_to_acc_skip_zero = 5'h0c,
    increment_skip_zero = 5'h0d,
    increment_to_acc_skip_zero = 5'h0e,
    set_byte = 5'h0f,
    set_bit = 5'h10,
    skip_bit_nonzero = 5'h11
  } op_t;

  // execute sequencer, gray coded
  typedef enum logic [1:0] {
    st_exec = 2'b00,
    st_dummy = 2'b01
  } seq_t;

  // status flags kept by the datapath
  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } flags_t;

  // combinational result of one instruction
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] mem;
    logic acc_we;
    logic mem_we;
    flags_t flags;
    logic skip;
  } result_t;

  // registered state of the top module
  typedef struct packed {
    seq_t seq;
    logic [7:0] acc;
    flags_t flags;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic acc_we;
    logic skip;
    logic discard;
    logic busy;
    logic done;
  } state_t;
endpackage

/* hw/rssd_alu_if.sv */
`timescale 1ns/1ps
`default_nettype none
// operands to the alu and result back
interface rssd_alu_if;
  rssd_pkg::op_t op;
  logic [7:0] acc;
  logic [7:0] mem;
  logic [2:0] bit_sel;
  rssd_pkg::flags_t flags;
  rssd_pkg::result_t res;
  modport core (output op, output acc, output mem, output bit_sel, output flags, input res);
  modport alu (input op, input acc, input mem, input bit_sel, input flags, output res);
endinterface
`default_nettype wire

/* hw/rotate_subtract_skip_datapath.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rssd_defs.svh"
// Summary of operation
// - rotate memory left, bit7 to bit0, flags kept
// - rotate left into accumulator, memory kept
// - rotate memory left through carry
// - rotate left through carry into accumulator
// - rotate memory right, bit0 to bit7
// - rotate right into accumulator, memory kept
// - rotate memory right through carry
// - rotate right through carry into accumulator
// - acc plus inverted memory plus carry to acc
// - same subtraction result written to memory
// - decrement memory, skip on zero, flags kept
// - skip discards prefetch, adds one dummy cycle
// - decrement into accumulator, skip on zero
// - increment memory, skip on wrap to zero
// - increment into accumulator, skip on zero
// - set memory byte to all ones
// - set selected bit of memory byte
// - skip when selected memory bit is one
module rotate_subtract_skip_datapath
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // instruction issue
  input wire logic i_issue,
  input wire logic [4:0] i_op,
  input wire logic [2:0] i_bit_sel,
  // data memory read byte
  input wire logic [7:0] i_mem_rdata,
  // data memory write back
  output logic o_mem_we,
  output logic [7:0] o_mem_wdata,
  // accumulator and flags
  output logic [7:0] o_acc,
  output logic o_acc_we,
  output logic o_overflow_flag,
  output logic o_zero_flag,
  output logic o_aux_carry_flag,
  output logic o_carry_flag,
  // sequencing to the fetch unit
  output logic o_skip,
  output logic o_discard,
  output logic o_busy,
  output logic o_done
);
  rssd_pkg::state_t state;
  rssd_pkg::state_t next_state;
  logic accept;

  rssd_alu_if alu_bus();

  // operands to the alu
  assign alu_bus.op = rssd_pkg::op_t'(i_op);
  assign alu_bus.acc = state.acc;
  assign alu_bus.mem = i_mem_rdata;
  assign alu_bus.bit_sel = i_bit_sel;
  assign alu_bus.flags = state.flags;

  rssd_alu u_alu
  (
    .bus(alu_bus.alu)
  );

  // an issue is taken only in the execute state
  assign accept = i_issue && (state.seq == rssd_pkg::st_exec);

  // next state
  always_comb
  begin
    next_state = state;
    next_state.mem_we = 1'b0;
    next_state.acc_we = 1'b0;
    next_state.skip = 1'b0;
    next_state.discard = 1'b0;
    next_state.done = 1'b0;
    case (state.seq)
      rssd_pkg::st_exec:
      begin
        if (accept)
        begin
          next_state.flags = alu_bus.res.flags;
          next_state.mem_we = alu_bus.res.mem_we;
          next_state.mem_wdata = alu_bus.res.mem;
          next_state.acc_we = alu_bus.res.acc_we;
          if (alu_bus.res.acc_we)
          begin
            next_state.acc = alu_bus.res.acc;
          end
          if (alu_bus.res.skip)
          begin
            // prefetched word is dropped, one dummy cycle follows
            next_state.skip = 1'b1;
            next_state.discard = 1'b1;
            next_state.busy = 1'b1;
            next_state.seq = rssd_pkg::st_dummy;
          end
          else
          begin
            next_state.done = 1'b1;
          end
        end
      end
      rssd_pkg::st_dummy:
      begin
        // dummy cycle ends the two cycle instruction
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
        next_state.seq = rssd_pkg::st_exec;
      end
      default:
      begin
        next_state.seq = rssd_pkg::st_exec;
        next_state.busy = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state.seq <= rssd_pkg::st_exec;
      state.acc <= `RSSD_ACC_RESET;
      // flag reset values, carry kept apart from the other flags
      state.flags <= '{overflow_flag: `RSSD_FLAG_RESET, zero_flag: `RSSD_FLAG_RESET,
        aux_carry_flag: `RSSD_FLAG_RESET, carry_flag: `RSSD_CARRY_RESET};
      state.mem_wdata <= `RSSD_ZERO;
      state.mem_we <= 1'b0;
      state.acc_we <= 1'b0;
      state.skip <= 1'b0;
      state.discard <= 1'b0;
      state.busy <= 1'b0;
      state.done <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // outputs straight from the state flops
  assign o_mem_we = state.mem_we;
  assign o_mem_wdata = state.mem_wdata;
  assign o_acc = state.acc;
  assign o_acc_we = state.acc_we;
  assign o_overflow_flag = state.flags.overflow_flag;
  assign o_zero_flag = state.flags.zero_flag;
  assign o_aux_carry_flag = state.flags.aux_carry_flag;
  assign o_carry_flag = state.flags.carry_flag;
  assign o_skip = state.skip;
  assign o_discard = state.discard;
  assign o_busy = state.busy;
  assign o_done = state.done;
endmodule // rotate_subtract_skip_datapath
`default_nettype wire

/* verif/rssd_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rssd_chk
(
  // clock and inputs
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_issue,
  input wire logic [4:0] i_op,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_mem_rdata,
  // outputs
  input wire logic o_mem_we,
  input wire logic [7:0] o_mem_wdata,
  input wire logic [7:0] o_acc,
  input wire logic o_acc_we,
  input wire logic o_overflow_flag,
  input wire logic o_zero_flag,
  input wire logic o_aux_carry_flag,
  input wire logic o_carry_flag,
  input wire logic o_skip,
  input wire logic o_discard,
  input wire logic o_busy,
  input wire logic o_done
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  logic take;
  logic c_q, b_q;
  logic [7:0] m_q;
  logic [8:0] d_q;
  // accepted at this edge; busy cycles refuse
  assign take = i_issue && !o_busy;
  // operands of the accepted instruction, one cycle behind
  always_ff @(posedge i_clk)
  begin
    m_q <= i_mem_rdata;
    c_q <= o_carry_flag;
    b_q <= i_mem_rdata[i_bit_sel];
    d_q <= {1'b0, o_acc} + {1'b0, ~i_mem_rdata} + {8'h00, o_carry_flag};
  end
  // plain finish, or skip followed by one quiet dummy cycle
  sequence s_plain;
    o_done && !o_skip && !o_busy;
  endsequence
  sequence s_dummy;
    o_skip && o_discard && o_busy && !o_done ##1 o_done && !o_busy && !o_mem_we && !o_acc_we;
  endsequence
  a_one_answer: assert property (take |=> s_plain or s_dummy)
    else $error("bad completion");
  a_rotl_mem: assert property (take && i_op == rssd_pkg::rotate_left_mem |=> o_mem_we && !o_acc_we
    && o_mem_wdata == {m_q[6:0], m_q[7]} && $stable(o_carry_flag)) else $error("rotate left");
  a_rlc_mem: assert property (take && i_op == rssd_pkg::rotate_left_carry_mem |=> o_mem_we
    && o_mem_wdata == {m_q[6:0], c_q} && o_carry_flag == m_q[7]) else $error("rotate left carry");
  a_rrc_acc: assert property (take && i_op == rssd_pkg::rotate_right_carry_to_acc |=> o_acc_we
    && !o_mem_we && o_acc == {c_q, m_q[7:1]} && o_carry_flag == m_q[0]) else $error("rotate right carry");
  a_sub_acc: assert property (take && i_op == rssd_pkg::subtract_borrow_to_acc |=> o_acc == d_q[7:0]
    && o_carry_flag == d_q[8] && o_zero_flag == (d_q[7:0] == 8'h00)) else $error("subtract acc");
  a_sub_mem: assert property (take && i_op == rssd_pkg::subtract_borrow_to_mem |=> o_mem_we
    && o_mem_wdata == d_q[7:0] && o_carry_flag == d_q[8]) else $error("subtract mem");
  a_dec_skip: assert property (take && i_op == rssd_pkg::decrement_skip_zero |=> o_mem_we
    && o_mem_wdata == m_q - 8'h01 && o_skip == (m_q == 8'h01) && $stable(o_zero_flag)) else $error("dec");
  a_bit_skip: assert property (take && i_op == rssd_pkg::skip_bit_nonzero |=> !o_mem_we
    && o_skip == b_q) else $error("bit skip");
  a_set_byte: assert property (take && i_op == rssd_pkg::set_byte |=> o_mem_we && !o_acc_we
    && o_mem_wdata == 8'hff && $stable(o_carry_flag)) else $error("set byte");
  a_inc_acc: assert property (take && i_op == rssd_pkg::increment_to_acc_skip_zero |=> o_acc_we
    && !o_mem_we && o_acc == m_q + 8'h01 && o_skip == (m_q == 8'hff)) else $error("inc acc");
endmodule // rssd_chk
bind rotate_subtract_skip_datapath rssd_chk chk (.i_clk, .i_reset_n, .i_issue, .i_op, .i_bit_sel, .i_mem_rdata,
  .o_mem_we, .o_mem_wdata, .o_acc, .o_acc_we, .o_overflow_flag, .o_zero_flag, .o_aux_carry_flag, .o_carry_flag,
  .o_skip, .o_discard, .o_busy, .o_done);
`default_nettype wire

/* verif/rotate_subtract_skip_datapath_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_skip_datapath_tb;
  logic i_clk, i_reset_n, i_issue;
  logic [4:0] i_op;
  logic [2:0] i_bit_sel;
  logic [7:0] i_mem_rdata, o_mem_wdata, o_acc, a;
  logic o_mem_we, o_acc_we, o_overflow_flag, o_zero_flag, o_aux_carry_flag, o_carry_flag;
  logic o_skip, o_discard, o_busy, o_done, c, ov, z, acf;
  int mismatches, num_checks;
  // device under test
  rotate_subtract_skip_datapath dut (.i_clk, .i_reset_n, .i_issue, .i_op, .i_bit_sel, .i_mem_rdata, .o_mem_we,
    .o_mem_wdata, .o_acc, .o_acc_we, .o_overflow_flag, .o_zero_flag, .o_aux_carry_flag, .o_carry_flag,
    .o_skip, .o_discard, .o_busy, .o_done);
  // 40 mhz clock
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // one idle cycle
  task automatic idle;
    i_issue = 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  // issue one instruction, predict and judge its answer
  task automatic run(input logic [4:0] op, input logic [7:0] m, input logic [2:0] bs);
    logic [8:0] s;
    logic [4:0] lo;
    logic [7:0] r;
    logic mw, aw, sk;
    s = {1'b0, a} + {1'b0, ~m} + {8'h00, c};
    lo = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c};
    r = m;
    mw = op inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h0a, 5'h0b, 5'h0d, 5'h0f, 5'h10};
    aw = op inside {5'h02, 5'h04, 5'h06, 5'h08, 5'h09, 5'h0c, 5'h0e};
    case (op)
      5'h01, 5'h02: r = {m[6:0], m[7]};
      5'h03, 5'h04:
      begin
        r = {m[6:0], c};
        c = m[7];
      end
      5'h05, 5'h06: r = {m[0], m[7:1]};
      5'h07, 5'h08:
      begin
        r = {c, m[7:1]};
        c = m[0];
      end
      5'h09, 5'h0a:
      begin
        r = s[7:0];
        {ov, z, acf, c} = {a[7] != m[7] && s[7] != a[7], s[7:0] == 8'h00, lo[4], s[8]};
      end
      5'h0b, 5'h0c: r = m - 8'h01;
      5'h0d, 5'h0e: r = m + 8'h01;
      5'h0f: r = 8'hff;
      5'h10: r = m | (8'h01 << bs);
      default: r = m;
    endcase
    sk = (op inside {[5'h0b:5'h0e]} && r == 8'h00) || (op == 5'h11 && m[bs]);
    if (aw)
      a = r;
    i_issue = 1'b1;
    i_op = op;
    i_mem_rdata = m;
    i_bit_sel = bs;
    @(posedge i_clk);
    #1;
    chk({2'b00, o_mem_we, o_acc_we, o_skip, o_discard, o_busy, o_done}, {2'b00, mw, aw, sk, sk, sk, !sk}, "strobes");
    if (mw)
      chk(o_mem_wdata, r, "mem");
    chk(o_acc, a, "acc");
    chk({4'h0, o_overflow_flag, o_zero_flag, o_aux_carry_flag, o_carry_flag}, {4'h0, ov, z, acf, c}, "flags");
    if (sk)
    begin
      i_issue = 1'b0;
      @(posedge i_clk);
      #1;
      chk({5'h00, o_skip, o_busy, o_done}, 8'h01, "dummy");
    end
  endtask
  // quiet state after reset
  task automatic t_reset;
    chk(o_acc, 8'h00, "acc");
    chk({2'b00, o_overflow_flag, o_zero_flag, o_aux_carry_flag, o_carry_flag, o_busy, o_done}, 8'h00, "reset");
    $display("test reset done");
  endtask
  // every rotate back to back, carry toggling
  task automatic t_rotate;
    for (int d = 0; d < 2; d++)
      for (int k = 1; k <= 8; k++)
        run(k[4:0], d ? 8'h6a : 8'h95, 3'h0);
    idle;
    $display("test rotate done");
  endtask
  // borrow subtraction: overflow, zero, aux and carry cases
  task automatic t_subtract;
    logic [16:0] tv [4];
    tv = '{{8'h80, 8'h01, 1'b1}, {8'h05, 8'h05, 1'b1}, {8'h10, 8'h01, 1'b0}, {8'h7f, 8'h80, 1'b1}};
    for (int k = 0; k < 8; k++)
    begin
      run(rssd_pkg::rotate_left_carry_mem, {tv[k % 4][0], 7'h00}, 3'h0);
      run(rssd_pkg::rotate_left_to_acc, {tv[k % 4][9], tv[k % 4][16:10]}, 3'h0);
      run(k < 4 ? 5'h09 : 5'h0a, tv[k % 4][8:1], 3'h0);
    end
    idle;
    $display("test subtract done");
  endtask
  // increment and decrement with and without skip
  task automatic t_incdec;
    for (int k = 11; k <= 14; k++)
    begin
      run(k[4:0], 8'h01, 3'h0);
      run(k[4:0], 8'hff, 3'h0);
    end
    idle;
    $display("test incdec done");
  endtask
  // byte set, every bit set and tested
  task automatic t_bits;
    run(rssd_pkg::set_byte, 8'h00, 3'h0);
    for (int k = 0; k < 8; k++)
    begin
      run(rssd_pkg::set_bit, 8'h5a, k[2:0]);
      run(rssd_pkg::skip_bit_nonzero, 8'ha5, k[2:0]);
    end
    idle;
    $display("test bits done");
  endtask
  // issue held through the dummy cycle is ignored
  task automatic t_refuse;
    i_issue = 1'b1;
    i_op = rssd_pkg::increment_skip_zero;
    i_mem_rdata = 8'hff;
    @(posedge i_clk);
    #1;
    chk({6'h00, o_busy, o_mem_we}, 8'h03, "skip");
    chk(o_mem_wdata, 8'h00, "wrap");
    i_op = rssd_pkg::set_byte;
    @(posedge i_clk);
    #1;
    chk({6'h00, o_done, o_mem_we}, 8'h02, "refused");
    i_issue = 1'b0;
    @(posedge i_clk);
    #1;
    chk({6'h00, o_done, o_mem_we}, 8'h00, "idle");
    run(rssd_pkg::op_none, 8'h00, 3'h0);
    idle;
    $display("test refuse done");
  endtask
  // reset in mid run clears accumulator and flags again
  task automatic t_reset_mid;
    run(rssd_pkg::rotate_left_carry_to_acc, 8'hff, 3'h0);
    i_issue = 1'b0;
    i_reset_n = 1'b0;
    @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    {a, c, ov, z, acf} = '0;
    t_reset;
    run(rssd_pkg::rotate_right_to_acc, 8'h01, 3'h0);
    idle;
  endtask
  // counts and verdict
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // reset then scenarios
  initial
  begin
    {i_reset_n, i_issue, i_op, i_bit_sel, i_mem_rdata} = '0;
    {a, c, ov, z, acf} = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (10) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    t_reset;
    t_rotate;
    t_subtract;
    t_incdec;
    t_bits;
    t_refuse;
    t_reset_mid;
    stop_test;
  end
  // watchdog, several times the expected span
  initial
  begin
    repeat (1000) @(posedge i_clk);
    mismatches++;
    stop_test;
  end
endmodule // rotate_subtract_skip_datapath_tb
`default_nettype wire
